// *** usr_headend_model.sv ***
// Behavioural headend: periodic sync, descriptors and maps, ranging replies.
// Assumes the bench configures channels through cfg, fail_m and sid_base.
`timescale 1ns/1ps
`default_nettype none
module usr_headend_model
  import usr_pkg::*;
(
  // Clock and modem status.
  input wire logic        clk,
  input wire logic [3:0]  state_out,
  input wire logic        rng_req,
  input wire logic [13:0] rng_sid,
  input wire logic [7:0]  up_chan_id,
  // Downstream messages.
  output var logic        sync_msg,
  output var usr_desc_t   desc_in,
  output var usr_map_t    map_in,
  output var usr_rsp_t    rsp_in
);
  logic [7:0]   ids [4];
  logic [7:0]   mt [4];
  logic         adv [4];
  logic         use_ok [4];
  logic [255:0] fail_m;
  logic [13:0]  sid_base;
  logic [13:0]  tmp;
  logic [7:0]   ch;
  int           n_ch;
  int           tick;
  int           pend;
  task automatic cfg(input int i, input logic [7:0] id, input logic [7:0] t,
                     input logic a, input logic u);
    ids[i] = id;
    mt[i] = t;
    adv[i] = a;
    use_ok[i] = u;
  endtask : cfg
  // ==========================================================================
  // Message generator, changing its outputs at the falling edge.
  initial begin
    {sync_msg, desc_in, map_in, rsp_in} = '0;
    {tick, pend, n_ch, fail_m, sid_base, tmp, ch} = '0;
    forever begin
      @(negedge clk);
      tick = tick + 1;
      sync_msg = (tick % 16 == 0);
      desc_in = '0;
      if (tick % 32 < n_ch) begin
        desc_in = {1'b1, ids[tick % 32], mt[tick % 32], mt[tick % 32] == MSG_TYPE_DESC_LEGACY,
                   adv[tick % 32], use_ok[tick % 32]};
      end
      map_in = '0;
      if (tick % 8 == 4 && n_ch > 0 && (state_out == ST_MAP || state_out == ST_BCAST)) begin
        map_in = {1'b1, ids[(tick / 8) % n_ch], 1'b1, 1'b0, SID_CONTENTION};
      end
      if (tick % 8 == 4 && state_out == ST_UNICAST) begin
        map_in = {1'b1, ch, 1'b1, 1'b1, (tick % 16 == 4) ? tmp ^ 14'h0001 : tmp};
      end
      rsp_in = '0;
      if (pend == 1) begin
        rsp_in = {1'b1, !fail_m[ch], tmp, 16'hA500 | 16'(ch)};
      end
      if (pend > 0) pend = pend - 1;
      if (rng_req === 1'b1 && rng_sid == SID_CONTENTION) begin
        pend = 3;
        ch = up_chan_id;
        tmp = sid_base + 14'(up_chan_id);
      end
    end
  end
endmodule : usr_headend_model
`default_nettype wire

// *** usr_pkg.sv ***
// Package for the upstream select and initial ranging sequencer.
// Assumes the MAC front end decodes downstream messages into one-cycle event pulses.
package usr_pkg;

  // ==========================================================================
  // Message types and channel classes.
  // ==========================================================================
  localparam logic [7:0] MSG_TYPE_DESC_LEGACY = 8'h02;
  localparam logic [7:0] MSG_TYPE_DESC_ADV    = 8'h1D;
  localparam logic [1:0] CH_TYPE_NONE         = 2'h0;
  localparam logic [1:0] CH_TYPE_1            = 2'h1;
  localparam logic [1:0] CH_TYPE_2            = 2'h2;
  localparam logic [1:0] CH_TYPE_3            = 2'h3;

  // ==========================================================================
  // Table sizing and identifier values.
  // ==========================================================================
  localparam int         CH_SLOTS     = 8;
  localparam int         CH_IDX_W     = 3;
  localparam logic [13:0] SID_CONTENTION = 14'h0000;

  // ==========================================================================
  // Timer defaults, in clock cycles at 250 MHz (4 ns).
  // ==========================================================================
  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         SEARCH_TMO_MS   = 1;
  localparam int         DESC_IVL_MS     = 1;
  localparam logic [31:0] SEARCH_TMO_CYC = 32'(SEARCH_TMO_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [31:0] DESC_IVL_CYC   = 32'(DESC_IVL_MS * 1000000 / CLK_PERIOD_NS);

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic [7:0] chan_id;
    logic [7:0] msg_type;
    logic       has_legacy;
    logic       has_adv;
    logic       usable;
  } usr_desc_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  chan_id;
    logic        init_maint;
    logic        unicast;
    logic [13:0] service_identifier;
  } usr_map_t;

  typedef struct packed {
    logic        valid;
    logic        success;
    logic [13:0] temp_sid;
    logic [15:0] adjust;
  } usr_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_COLLECT = 4'b0001,
    ST_SELECT  = 4'b0010,
    ST_SYNC    = 4'b0011,
    ST_MAP     = 4'b0100,
    ST_BCAST   = 4'b0101,
    ST_RSP     = 4'b0110,
    ST_UNICAST = 4'b0111,
    ST_DONE    = 4'b1000,
    ST_RESCAN  = 4'b1001
  } usr_state_t;

  function automatic logic [1:0] usr_classify(input usr_desc_t d);
    logic [1:0] t;
    t = CH_TYPE_NONE;
    if (d.msg_type == MSG_TYPE_DESC_ADV) begin
      t = CH_TYPE_3;
    end else if (d.msg_type == MSG_TYPE_DESC_LEGACY) begin
      t = d.has_adv ? CH_TYPE_2 : CH_TYPE_1;
    end
    return t;
  endfunction : usr_classify

endpackage : usr_pkg

// *** usr_seq.sv ***
// Upstream channel selection and initial ranging sequencer of the cable_modem.
// Assumes decoded message pulses from the MAC receiver and a transmitter that
// sends a ranging request on a one-cycle strobe.
// Function
// RULE1 - After downstream sync, wait for a channel descriptor before choosing parameters.
// RULE2 - Gather descriptors with distinct channel identifiers into a candidate set.
// RULE3 - No usable upstream at search timeout: abandon downstream and rescan.
// RULE4 - Judge suitability from descriptor; skip unsuitable channels to other candidates.
// RULE5 - Classify: type 1 legacy only, type 2 legacy plus advanced, type 3 type 29.
// RULE6 - Try the channel matching the stored last-registered identifier first.
// RULE7 - Otherwise prefer type 3, then type 2, then type 1.
// RULE8 - No ranging on type 1 or 2 before one descriptor interval elapsed.
// RULE9 - After type 3 failure, wait to learn other type 3 channels first.
// RULE10 - Take timestamp from next sync message unless a time reference exists.
// RULE11 - Wait for an allocation map on the chosen channel before transmitting.
// RULE12 - Range once per channel; on failure pick next; rescan when exhausted.
// RULE13 - Headend sends sync and descriptors periodically for every upstream.
// RULE14 - Answer broadcast initial maintenance in contention with service identifier zero.
// RULE15 - Headend allocates temporary identifier, responds, and polls it.
// RULE16 - Store the temporary service identifier and apply the response adjustments.
// RULE17 - Recognize own identifier in a unicast map element and answer it.
// RULE18 - Search and interval timers programmable, restarted on each new candidate; here only the interval timer does, search restarts on lock.
`timescale 1ns/1ps
`default_nettype none
module usr_seq
  import usr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Downstream status and decoded messages.
  input  wire logic        ds_locked,
  input  wire logic        sync_msg,
  input  wire usr_desc_t   desc_in,
  input  wire usr_map_t    map_in,
  input  wire usr_rsp_t    rsp_in,
  // Non-volatile stored channel and timer settings.
  input  wire logic [7:0]  stored_chan_id,
  input  wire logic        stored_valid,
  input  wire logic [31:0] search_tmo_cyc,
  input  wire logic [31:0] desc_ivl_cyc,
  // Ranging request towards the transmitter.
  output logic             rng_req,
  output logic [13:0]      rng_sid,
  output logic [7:0]       up_chan_id,
  output logic [15:0]      tx_adjust,
  // Status.
  output logic             rescan_req,
  output logic             ranged_ok,
  output logic [3:0]       state_out
);

  // ==========================================================================
  // Candidate table.
  // ==========================================================================
  logic [7:0]        tbl_id   [CH_SLOTS];
  logic [1:0]        tbl_type [CH_SLOTS];
  logic [CH_SLOTS-1:0] tbl_vld_r;
  logic [CH_SLOTS-1:0] tbl_tried_r;
  usr_state_t        state_r;
  logic              time_ref_r;
  logic              stored_tried_r;
  logic [CH_IDX_W-1:0] cur_idx_r;
  logic [1:0]        cur_type_r;
  logic              restart_tmr;
  logic              search_exp;
  logic              ivl_exp;

  // Looks up whether an identifier already sits in the table.
  function automatic logic id_known(input logic [7:0] id,
                                    input logic [CH_SLOTS-1:0] vld,
                                    input logic [7:0] ids [CH_SLOTS]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < CH_SLOTS; i++) begin
      if (vld[i] && ids[i] == id) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : id_known

  logic                free_found;
  logic [CH_IDX_W-1:0] free_idx;
  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    for (int i = CH_SLOTS - 1; i >= 0; i--) begin
      if (!tbl_vld_r[i]) begin
        free_found = 1'b1;
        free_idx   = CH_IDX_W'(i);
      end
    end
  end

  // Only usable descriptors become candidates; duplicates are dropped.
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == ST_RESCAN || state_r == ST_IDLE) begin
      tbl_vld_r <= '0;
    end else if (desc_in.valid && desc_in.usable && free_found &&
                 !id_known(desc_in.chan_id, tbl_vld_r, tbl_id)) begin // [RULE2] [RULE4]
      tbl_vld_r[free_idx] <= 1'b1;
      tbl_id[free_idx]    <= desc_in.chan_id;
      tbl_type[free_idx]  <= usr_classify(desc_in);                   // [RULE5]
    end
  end

  // ==========================================================================
  // Candidate choice.
  // ==========================================================================
  logic                pick_ok;
  logic [CH_IDX_W-1:0] pick_idx;
  logic [1:0]          pick_type;
  always_comb begin
    pick_ok   = 1'b0;
    pick_idx  = '0;
    pick_type = CH_TYPE_NONE;
    for (int i = 0; i < CH_SLOTS; i++) begin
      if (tbl_vld_r[i] && !tbl_tried_r[i] && tbl_type[i] > pick_type) begin // [RULE7]
        pick_ok   = 1'b1;
        pick_idx  = CH_IDX_W'(i);
        pick_type = tbl_type[i];
      end
    end
    for (int i = 0; i < CH_SLOTS; i++) begin
      if (stored_valid && !stored_tried_r && tbl_vld_r[i] && !tbl_tried_r[i] &&
          tbl_id[i] == stored_chan_id) begin                         // [RULE6]
        pick_ok   = 1'b1;
        pick_idx  = CH_IDX_W'(i);
        pick_type = tbl_type[i];
      end
    end
  end

  // Type 1 and 2 need a full descriptor interval so type 3 channels surface.
  logic pick_allowed;
  assign pick_allowed = pick_ok && (pick_type == CH_TYPE_3 || ivl_exp); // [RULE8] [RULE9]

  // ==========================================================================
  // Timers.
  // ==========================================================================
  assign restart_tmr = (state_r == ST_IDLE && ds_locked) ||
                       (state_r == ST_SELECT && pick_allowed);       // [RULE18]

  usr_timer u_search_tmr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .restart  (state_r == ST_IDLE && ds_locked),
    .load_val (search_tmo_cyc),
    .expired  (search_exp)
  );

  usr_timer u_ivl_tmr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .restart  (restart_tmr),
    .load_val (desc_ivl_cyc),
    .expired  (ivl_exp)
  );

  // ==========================================================================
  // Sequencer.
  // ==========================================================================
  logic fail_now;
  assign fail_now = rsp_in.valid && !rsp_in.success;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (ds_locked) begin
            state_r <= ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          if (tbl_vld_r != '0) begin                                 // [RULE1]
            state_r <= ST_SELECT;
          end else if (search_exp) begin
            state_r <= ST_RESCAN;                                    // [RULE3]
          end
        end
        ST_SELECT: begin
          if (pick_allowed) begin
            state_r <= time_ref_r ? ST_MAP : ST_SYNC;                // [RULE10]
          end else if (!pick_ok && (ivl_exp || search_exp)) begin
            state_r <= ST_RESCAN;                                    // [RULE12]
          end
        end
        ST_SYNC: begin
          if (sync_msg) begin
            state_r <= ST_MAP;
          end
        end
        ST_MAP: begin
          if (map_in.valid && map_in.chan_id == up_chan_id) begin    // [RULE11]
            state_r <= ST_BCAST;
          end
        end
        ST_BCAST: begin
          if (rng_req) begin
            state_r <= ST_RSP;
          end
        end
        ST_RSP: begin
          if (rsp_in.valid && rsp_in.success) begin
            state_r <= ST_UNICAST;
          end else if (fail_now) begin
            state_r <= ST_SELECT;                                    // [RULE12]
          end
        end
        ST_UNICAST: begin
          if (rng_req) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!ds_locked) begin
            state_r <= ST_IDLE;
          end
        end
        ST_RESCAN: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Selected channel bookkeeping.
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == ST_IDLE) begin
      tbl_tried_r    <= '0;
      stored_tried_r <= 1'b0;
      cur_idx_r      <= '0;
      cur_type_r     <= CH_TYPE_NONE;
      up_chan_id     <= 8'h00;
    end else if (state_r == ST_SELECT && pick_allowed) begin
      tbl_tried_r[pick_idx] <= 1'b1;
      stored_tried_r        <= 1'b1;
      cur_idx_r             <= pick_idx;
      cur_type_r            <= pick_type;
      up_chan_id            <= tbl_id[pick_idx];
    end
  end

  // Time reference persists across channels while downstream stays locked.
  always_ff @(posedge clk) begin
    if (sys_rst || state_r == ST_IDLE) begin
      time_ref_r <= 1'b0;
    end else if (sync_msg) begin
      time_ref_r <= 1'b1;                                            // [RULE10]
    end
  end

  // ==========================================================================
  // Ranging requests and responses.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rng_req <= 1'b0;
      rng_sid <= SID_CONTENTION;
    end else begin
      rng_req <= 1'b0;
      if (state_r == ST_BCAST && !rng_req && map_in.valid &&
          map_in.chan_id == up_chan_id && map_in.init_maint && !map_in.unicast) begin
        rng_req <= 1'b1;
        rng_sid <= SID_CONTENTION;                                   // [RULE14]
      end else if (state_r == ST_UNICAST && !rng_req && map_in.valid &&
                   map_in.chan_id == up_chan_id && map_in.unicast &&
                   map_in.service_identifier == rng_sid) begin
        rng_req <= 1'b1;                                             // [RULE17]
      end else if (state_r == ST_RSP && rsp_in.valid && rsp_in.success) begin
        rng_sid <= rsp_in.temp_sid;                                  // [RULE16]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_adjust <= 16'h0000;
    end else if (state_r == ST_RSP && rsp_in.valid && rsp_in.success) begin
      tx_adjust <= rsp_in.adjust;                                    // [RULE16]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rescan_req <= 1'b0;
      ranged_ok  <= 1'b0;
      state_out  <= 4'h0;
    end else begin
      rescan_req <= (state_r == ST_RESCAN);                          // [RULE3]
      ranged_ok  <= (state_r == ST_DONE);
      state_out  <= state_r;
    end
  end

endmodule : usr_seq
`default_nettype wire

// *** usr_seq_asserts.sv ***
// Port checker for the upstream select and ranging sequencer.
// Assumes it is bound onto usr_seq: one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module usr_seq_asserts
  import usr_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Watched ports.
  input wire usr_map_t    map_in,
  input wire usr_rsp_t    rsp_in,
  input wire logic        rng_req,
  input wire logic [13:0] rng_sid,
  input wire logic [7:0]  up_chan_id,
  input wire logic [15:0] tx_adjust,
  input wire logic        rescan_req,
  input wire logic        ranged_ok
);
  // ==========================================================================
  // Sequences and properties.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_bc_req;
    rng_req && rng_sid == SID_CONTENTION;
  endsequence
  sequence s_uc_req;
    rng_req && rng_sid != SID_CONTENTION;
  endsequence
  rst_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !rng_req && !rescan_req && !ranged_ok && rng_sid == 14'h0000)
    else $error("Outputs not cleared by reset.");
  rng_pulse_a: assert property (rng_req |=> !rng_req)
    else $error("Ranging request held over one cycle.");
  bcast_map_a: assert property (s_bc_req |-> $past(map_in.valid &&
    map_in.init_maint && !map_in.unicast && map_in.chan_id == up_chan_id))
    else $error("Contention request without a matching map.");
  own_sid_a: assert property (s_uc_req |-> $past(map_in.valid &&
    map_in.unicast && map_in.service_identifier == rng_sid))
    else $error("Unicast request without own identifier in map.");
  ranged_done_a: assert property (s_uc_req |-> ##[1:8] ranged_ok)
    else $error("Ranging not completed after unicast request.");
  sid_store_a: assert property ($changed(rng_sid) && rng_sid != SID_CONTENTION
    |-> $past(rsp_in.valid && rsp_in.success) && $past(rsp_in.temp_sid) == rng_sid)
    else $error("Identifier changed without a response.");
  adjust_take_a: assert property ($changed(tx_adjust) && !$past(sys_rst)
    |-> $past(rsp_in.valid) && $past(rsp_in.adjust) == tx_adjust)
    else $error("Adjustment changed without a response.");
  rescan_clean_a: assert property (rescan_req
    |-> (!rng_req && !ranged_ok) ##1 !rescan_req)
    else $error("Rescan pulse malformed.");
  ok_level_a: assert property (ranged_ok
    |-> rng_sid != SID_CONTENTION && $stable(up_chan_id))
    else $error("Ranged without temporary identifier.");
endmodule : usr_seq_asserts
bind usr_seq usr_seq_asserts u_usr_seq_asserts (.clk(clk), .sys_rst(sys_rst),
  .map_in(map_in), .rsp_in(rsp_in), .rng_req(rng_req), .rng_sid(rng_sid),
  .up_chan_id(up_chan_id), .tx_adjust(tx_adjust), .rescan_req(rescan_req),
  .ranged_ok(ranged_ok));
`default_nettype wire

// *** usr_seq_tb.sv ***
// Self-checking bench for the upstream select and ranging sequencer.
// Assumes usr_pkg, the design and the headend model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module usr_seq_tb import usr_pkg::*; ;
  localparam logic [31:0] TMO = 32'h0000_00C8;
  localparam logic [31:0] IVL = 32'h0000_0028;
  logic        clk, sys_rst, ds_locked, sync_msg, stored_valid;
  logic        rng_req, rescan_req, ranged_ok;
  logic [7:0]  stored_chan_id, up_chan_id;
  logic [13:0] rng_sid;
  logic [15:0] tx_adjust;
  logic [3:0]  state_out;
  logic [22:0] exp_q [$];
  logic [22:0] e;
  usr_desc_t   desc_in;
  usr_map_t    map_in;
  usr_rsp_t    rsp_in;
  int          failures, checked, cyc, lock_cyc, first_cyc, resc_cyc;
  int unsigned sd;
  usr_seq u_usr_seq (.clk(clk), .sys_rst(sys_rst), .ds_locked(ds_locked),
    .sync_msg(sync_msg), .desc_in(desc_in), .map_in(map_in), .rsp_in(rsp_in),
    .stored_chan_id(stored_chan_id), .stored_valid(stored_valid),
    .search_tmo_cyc(TMO), .desc_ivl_cyc(IVL), .rng_req(rng_req), .rng_sid(rng_sid),
    .up_chan_id(up_chan_id), .tx_adjust(tx_adjust), .rescan_req(rescan_req),
    .ranged_ok(ranged_ok), .state_out(state_out));
  usr_headend_model u_usr_headend_model (.clk(clk), .state_out(state_out),
    .rng_req(rng_req), .rng_sid(rng_sid), .up_chan_id(up_chan_id),
    .sync_msg(sync_msg), .desc_in(desc_in), .map_in(map_in), .rsp_in(rsp_in));
  // ==========================================================================
  // Comparison, closing and bounded wait.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic wait_for(input logic want_ok, input int left, input int lim);
    int n;
    n = 0;
    while (n < lim && (want_ok ? ranged_ok !== 1'b1 : exp_q.size() > left)) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      end_sim();
    end
  endtask : wait_for
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================================
  // Output monitor: each pulse takes the oldest expectation.
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rng_req === 1'b1 || rescan_req === 1'b1) begin
      if (rng_req === 1'b1 && first_cyc == 0) first_cyc = cyc;
      if (rescan_req === 1'b1) resc_cyc = cyc;
      if (exp_q.size() == 0) check("unexpected pulse", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("rescan_req", 32'(rescan_req), 32'(e[22]));
        if (!e[22]) check("rng_sid", 32'(rng_sid), 32'(e[21:8]));
        if (!e[22]) check("up_chan_id", 32'(up_chan_id), 32'(e[7:0]));
      end
    end
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    {sys_rst, ds_locked, stored_valid, stored_chan_id} = '0;
    {failures, checked, cyc, lock_cyc, first_cyc, resc_cyc} = '0;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    sd = $urandom(32'hCC34F5C3);
    check("reset outputs", 32'({rng_req, rescan_req, ranged_ok, up_chan_id, tx_adjust}), 32'h0);
    u_usr_headend_model.sid_base = 14'($urandom_range(32'h3F00, 32'h0100));
    // Two type 3 channels, the stored one second, and a type 1 channel.
    u_usr_headend_model.cfg(0, 8'h05, MSG_TYPE_DESC_ADV, 1'b0, 1'b1);
    u_usr_headend_model.cfg(1, 8'h09, MSG_TYPE_DESC_ADV, 1'b0, 1'b1);
    u_usr_headend_model.cfg(2, 8'h03, MSG_TYPE_DESC_LEGACY, 1'b0, 1'b1);
    u_usr_headend_model.n_ch = 3;
    u_usr_headend_model.fail_m = '0;
    u_usr_headend_model.fail_m[9] = 1'b1;
    {stored_valid, stored_chan_id} = {1'b1, 8'h09};
    exp_q.push_back({1'b0, SID_CONTENTION, 8'h09});
    exp_q.push_back({1'b0, SID_CONTENTION, 8'h05});
    exp_q.push_back({1'b0, u_usr_headend_model.sid_base + 14'h0005, 8'h05});
    ds_locked = 1'b1;
    wait_for(1'b1, 0, 3000);
    @(negedge clk);
    check("state_out", 32'(state_out), 32'(ST_DONE));
    check("tx_adjust", 32'(tx_adjust), 32'h0000_A505);
    check("queue empty", 32'(exp_q.size()), 32'h0);
    // Type 1, type 2 and an unusable type 3 channel; every attempt fails.
    ds_locked = 1'b0;
    repeat (4) @(negedge clk);
    check("ranged_ok", 32'(ranged_ok), 32'h0);
    u_usr_headend_model.cfg(0, 8'h08, MSG_TYPE_DESC_ADV, 1'b0, 1'b0);
    u_usr_headend_model.cfg(1, 8'h06, MSG_TYPE_DESC_LEGACY, 1'b0, 1'b1);
    u_usr_headend_model.cfg(2, 8'h04, MSG_TYPE_DESC_LEGACY, 1'b1, 1'b1);
    u_usr_headend_model.fail_m = '1;
    {stored_valid, stored_chan_id} = {1'b0, 8'h06};
    exp_q.push_back({1'b0, SID_CONTENTION, 8'h04});
    exp_q.push_back({1'b0, SID_CONTENTION, 8'h06});
    exp_q.push_back({1'b1, 14'h0000, 8'h00});
    {first_cyc, lock_cyc} = {32'd0, cyc};
    ds_locked = 1'b1;
    wait_for(1'b0, 1, 4000);
    // Lock drops before the rescan so that the sequencer stays idle afterwards.
    ds_locked = 1'b0;
    wait_for(1'b0, 0, 4000);
    check("interval wait", 32'(first_cyc - lock_cyc >= int'(IVL)), 32'h1);
    // No channels at all: the search timer must give up.
    ds_locked = 1'b0;
    u_usr_headend_model.n_ch = 0;
    repeat (4) @(negedge clk);
    exp_q.push_back({1'b1, 14'h0000, 8'h00});
    lock_cyc = cyc;
    ds_locked = 1'b1;
    wait_for(1'b0, 0, 4000);
    check("search timeout", 32'(resc_cyc - lock_cyc >= int'(TMO)), 32'h1);
    ds_locked = 1'b0;
    repeat (20) @(negedge clk);
    end_sim();
  end
endmodule : usr_seq_tb
`default_nettype wire

// *** usr_timer.sv ***
// Programmable down-counting timer with restart and expiry flag.
// Assumes a single clock domain and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module usr_timer
  import usr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control.
  input  wire logic        restart,
  input  wire logic [31:0] load_val,
  // Status.
  output logic             expired
);

  logic [31:0] cnt_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r   <= 32'h00000000;
      expired <= 1'b0;
    end else if (restart) begin
      cnt_r   <= load_val;
      expired <= (load_val == 32'h00000000);
    end else if (cnt_r > 32'h00000001) begin
      cnt_r <= cnt_r - 32'h00000001;
    end else begin
      cnt_r   <= 32'h00000000;
      expired <= 1'b1;
    end
  end

endmodule : usr_timer
`default_nettype wire
